//--- verilog/psl_pkg.sv
// package with constants for the protective output and status indicator block
package psl_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int AUTO_RESET_S = 10;
	localparam int AUTO_RESET_CYC = AUTO_RESET_S * CLK_HZ;
	localparam int CHG_MON_NS = 20_000;
	localparam int CHG_MON_CYC = (CHG_MON_NS + 9) / 10;
	localparam int EDM_NS = 300_000;
	localparam int EDM_CYC = EDM_NS / 10;
	localparam int FLASH_CYC = 25_000_000;
	localparam int SAFE_DLY_DEF = 50_000_000;
	localparam int N_FUNC = 2;
	localparam int N_SIG = 9;
	localparam logic [1:0] LED_DARK = 2'h0;
	localparam logic [1:0] LED_RED = 2'h1;
	localparam logic [1:0] LED_GREEN = 2'h2;
	// signal source selector codes for the configurable signal outputs
	localparam logic [2:0] SRC_PROT = 3'h0;
	localparam logic [2:0] SRC_WARN = 3'h1;
	localparam logic [2:0] SRC_ERR = 3'h2;
	localparam logic [2:0] SRC_DIAG = 3'h3;
	localparam logic [2:0] SRC_STAT = 3'h4;
	typedef enum logic [1:0] {
		PF_OFF = 2'b00,
		PF_ARMED = 2'b01,
		PF_ON = 2'b11,
		PF_ERR = 2'b10
	} psl_pf_state_t;
endpackage : psl_pkg

//--- verilog/psl_chan.sv
// one protective function: output pair state, restart interlock, contactor check
`timescale 1ns/10ps
module psl_chan #(
	parameter int AUTO_RESET_CYC = psl_pkg::AUTO_RESET_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic field_occupied,
	input wire logic auto_restart,
	input wire logic restart_ack,
	input wire logic contactor_supervision_en,
	input wire logic contactor_fb,
	input wire logic ext_error,
	input wire logic ext_lock,
	output logic pair_on,
	output logic interlock_blocked,
	output logic err_active,
	output logic locked
);
	import psl_pkg::*;

	psl_pf_state_t st_q;
	logic [31:0] tmr_q;
	logic edm_err;
	logic err_ev;

	// contactor feedback must follow the output within the window
	assign edm_err = contactor_supervision_en && (tmr_q >= 32'(EDM_CYC)) &&
		(st_q == PF_ON ? contactor_fb : !contactor_fb) && !(st_q == PF_ERR);
	// a locking error switches the pair off as well; only its auto reset is barred
	assign err_ev = ext_error || ext_lock || edm_err;
	assign err_active = (st_q == PF_ERR);
	assign pair_on = (st_q == PF_ON);
	assign interlock_blocked = (st_q == PF_ARMED) && !auto_restart;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			locked <= 1'b0;
		else if (ext_lock)
			locked <= 1'b1;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q <= PF_OFF;
			tmr_q <= 32'h0000_0000;
		end
		else
		begin
			unique case (st_q)
				PF_OFF:
				begin
					if (err_ev)
						st_q <= PF_ERR;
					else if (!field_occupied)
						st_q <= PF_ARMED;
					tmr_q <= 32'h0000_0000;
				end
				PF_ARMED:
				begin
					if (err_ev)
						st_q <= PF_ERR;
					else if (field_occupied)
						st_q <= PF_OFF;
					else if (auto_restart || restart_ack)
						st_q <= PF_ON;
					tmr_q <= 32'h0000_0000;
				end
				PF_ON:
				begin
					// the error hold time must start from zero, not from the contactor count
					if (err_ev)
					begin
						st_q <= PF_ERR;
						tmr_q <= 32'h0000_0000;
					end
					else if (field_occupied)
						st_q <= PF_OFF;
					else if (tmr_q < 32'(EDM_CYC))
						tmr_q <= tmr_q + 32'h0000_0001;
				end
				PF_ERR:
				begin
					// auto reset lands in the off state, never straight back on
					if (!locked && !ext_lock && !ext_error && tmr_q >= 32'(AUTO_RESET_CYC - 1))
					begin
						st_q <= PF_OFF;
						tmr_q <= 32'h0000_0000;
					end
					else if (ext_error)
						tmr_q <= 32'h0000_0000;
					else if (tmr_q < 32'(AUTO_RESET_CYC))
						tmr_q <= tmr_q + 32'h0000_0001;
				end
			endcase
		end
	end
endmodule : psl_chan

//--- verilog/psl_top.sv
// safety output pairs, field pair changeover, signal outputs and status indicators
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module psl_top #(
	parameter int AUTO_RESET_CYC = psl_pkg::AUTO_RESET_CYC,
	parameter int SAFE_DLY_CYC = psl_pkg::SAFE_DLY_DEF,
	parameter int FLASH_CYC = psl_pkg::FLASH_CYC,
	parameter int CFG_WORDS = 16
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic POWER_ON,
	input wire logic TWO_FUNC_MODE,
	input wire logic SAFE_DELAY_EN,
	input wire logic [1:0] FIELD_OCCUPIED,
	input wire logic [1:0] WARN_OCCUPIED,
	input wire logic [1:0] AUTO_RESTART,
	input wire logic [1:0] RESTART_ACK,
	input wire logic [1:0] CONTACTOR_SUPERVISION_EN,
	input wire logic [1:0] CONTACTOR_FB,
	input wire logic [1:0] EXT_ERROR,
	input wire logic [1:0] EXT_LOCK,
	input wire logic [1:0] LINKED_ENABLE,
	input wire logic [6:0] FIELD_PAIR_REQ,
	input wire logic FIELD_PAIR_VALID,
	input wire logic [1:0] DIAG_IN,
	input wire logic [26:0] SIG_SEL,
	input wire logic UNIT_SWAP,
	input wire logic [7:0] CU_MEM_RDATA,
	output logic [3:0] CU_MEM_ADDR,
	output logic CFG_WR,
	output logic [3:0] CFG_WADDR,
	output logic [7:0] CFG_WDATA,
	output logic CFG_XFER_BUSY,
	output logic [1:0] SAFETY_SWITCH_OUTPUT_PAIR,
	output logic [6:0] ACTIVE_FIELD_PAIR,
	output logic FIELD_PAIR_FAULT,
	output logic [8:0] SIG_OUT,
	output logic [1:0] LED_OUT_A,
	output logic LED_INTERLOCK_A,
	output logic LED_WARN_A,
	output logic LED_WARN_B,
	output logic LED_INTERLOCK_B,
	output logic [1:0] LED_OUT_B
);
	import psl_pkg::*;

	logic [1:0] pair_on;
	logic [1:0] blocked;
	logic [1:0] err;
	logic [1:0] field_eff;
	logic [1:0] pair_q;
	logic [31:0] dly_q;
	logic [31:0] flash_cnt_q;
	logic flash_q;
	logic [6:0] pend_q;
	logic [31:0] chg_q;
	logic chg_busy_q;
	logic [4:0] sig_src [N_FUNC];
	logic [8:0] sig_q;
	logic [3:0] cfg_idx_q;
	logic cfg_busy_q;
	logic [1:0] out_led [N_FUNC];
	logic [1:0] il_led;
	logic [1:0] warn_q;

	//////////////////////////////////////////////////////////////////////////
	// protective functions
	// in single function mode function A's field drives both channels
	assign field_eff[0] = FIELD_OCCUPIED[0];
	assign field_eff[1] = TWO_FUNC_MODE ? FIELD_OCCUPIED[1] : FIELD_OCCUPIED[0];

	genvar g;
	generate
		for (g = 0; g < N_FUNC; g++)
		begin : g_func
			// the far side only acks with the field reported free
			psl_chan #(
				.AUTO_RESET_CYC(AUTO_RESET_CYC)
			) u_chan (
				.clk(CORE_CLK),
				.nrst(NRST),
				.field_occupied(field_eff[g] || chg_busy_q),
				.auto_restart(AUTO_RESTART[g]),
				.restart_ack(RESTART_ACK[g]),
				.contactor_supervision_en(CONTACTOR_SUPERVISION_EN[g]),
				.contactor_fb(CONTACTOR_FB[g]),
				.ext_error(EXT_ERROR[g] || FIELD_PAIR_FAULT),
				.ext_lock(EXT_LOCK[g]),
				.pair_on(pair_on[g]),
				.interlock_blocked(blocked[g]),
				.err_active(err[g]),
				.locked()
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// output pairs, with the optional safe delay on pair B
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			pair_q <= 2'h0;
			dly_q <= 32'h0000_0000;
		end
		else
		begin
			pair_q[0] <= pair_on[0];
			if (TWO_FUNC_MODE || !SAFE_DELAY_EN || err[1])
			begin
				pair_q[1] <= pair_on[1];
				dly_q <= 32'h0000_0000;
			end
			else if (pair_on[0])
			begin
				pair_q[1] <= pair_on[1];
				dly_q <= 32'h0000_0000;
			end
			else if (dly_q >= 32'(SAFE_DLY_CYC))
				pair_q[1] <= 1'b0;
			else if (pair_q[1])
				dly_q <= dly_q + 32'h0000_0001;
		end
	end
	assign SAFETY_SWITCH_OUTPUT_PAIR = pair_q;

	//////////////////////////////////////////////////////////////////////////
	// field pair changeover monitoring
	// a request that changes or drops mid-window is a fault; outputs are held off meanwhile, except pair B during its safe delay
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			pend_q <= 7'h00;
			chg_q <= 32'h0000_0000;
			chg_busy_q <= 1'b0;
			ACTIVE_FIELD_PAIR <= 7'h00;
			FIELD_PAIR_FAULT <= 1'b0;
		end
		else if (FIELD_PAIR_VALID && FIELD_PAIR_REQ != ACTIVE_FIELD_PAIR && !chg_busy_q)
		begin
			pend_q <= FIELD_PAIR_REQ;
			chg_busy_q <= 1'b1;
			chg_q <= 32'h0000_0000;
			FIELD_PAIR_FAULT <= (FIELD_PAIR_REQ > 7'h63);
		end
		else if (chg_busy_q)
		begin
			if (!FIELD_PAIR_VALID || FIELD_PAIR_REQ != pend_q)
			begin
				chg_busy_q <= 1'b0;
				FIELD_PAIR_FAULT <= 1'b1;
			end
			else if (chg_q >= 32'(CHG_MON_CYC - 1))
			begin
				chg_busy_q <= 1'b0;
				if (!FIELD_PAIR_FAULT)
					ACTIVE_FIELD_PAIR <= pend_q;
			end
			else
				chg_q <= chg_q + 32'h0000_0001;
		end
		else if (FIELD_PAIR_VALID && FIELD_PAIR_REQ == ACTIVE_FIELD_PAIR)
			FIELD_PAIR_FAULT <= 1'b0;
	end

	//////////////////////////////////////////////////////////////////////////
	// configurable signal outputs
	always_comb
	begin
		for (int i = 0; i < N_FUNC; i++)
		begin
			sig_src[i][SRC_PROT] = pair_on[i];
			sig_src[i][SRC_WARN] = WARN_OCCUPIED[i];
			sig_src[i][SRC_ERR] = err[i];
			sig_src[i][SRC_DIAG] = DIAG_IN[i];
			sig_src[i][SRC_STAT] = blocked[i];
		end
	end

	generate
		for (g = 0; g < N_SIG; g++)
		begin : g_sig
			// even outputs follow function A, odd ones function B; unused codes read low
			logic [2:0] grp;
			logic fsel;
			assign grp = SIG_SEL[g*3 +: 3];
			assign fsel = 1'(g % 2);
			always_ff @(posedge CORE_CLK or negedge NRST)
			begin
				if (!NRST)
					sig_q[g] <= 1'b0;
				else if (grp <= SRC_STAT)
					sig_q[g] <= sig_src[fsel][grp];
				else
					sig_q[g] <= 1'b0;
			end
		end
	endgenerate
	assign SIG_OUT = sig_q;

	//////////////////////////////////////////////////////////////////////////
	// configuration transfer after unit swap
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			cfg_busy_q <= 1'b0;
			cfg_idx_q <= 4'h0;
			CFG_WR <= 1'b0;
			CFG_WADDR <= 4'h0;
			CFG_WDATA <= 8'h00;
		end
		else
		begin
			CFG_WR <= cfg_busy_q;
			CFG_WADDR <= cfg_idx_q;
			CFG_WDATA <= CU_MEM_RDATA;
			if (UNIT_SWAP && !cfg_busy_q)
			begin
				cfg_busy_q <= 1'b1;
				cfg_idx_q <= 4'h0;
			end
			else if (cfg_busy_q)
			begin
				if (cfg_idx_q == 4'(CFG_WORDS - 1))
					cfg_busy_q <= 1'b0;
				cfg_idx_q <= cfg_idx_q + 4'h1;
			end
		end
	end
	assign CU_MEM_ADDR = cfg_idx_q;
	assign CFG_XFER_BUSY = cfg_busy_q || CFG_WR;

	//////////////////////////////////////////////////////////////////////////
	// status indicators
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			flash_cnt_q <= 32'h0000_0000;
			flash_q <= 1'b0;
		end
		else if (flash_cnt_q >= 32'(FLASH_CYC - 1))
		begin
			flash_cnt_q <= 32'h0000_0000;
			flash_q <= !flash_q;
		end
		else
			flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
	end

	always_comb
	begin
		for (int i = 0; i < N_FUNC; i++)
		begin
			if (!POWER_ON)
				out_led[i] = LED_DARK;
			else if (err[i])
				out_led[i] = flash_q ? LED_RED : LED_DARK;
			else if (pair_q[i])
				out_led[i] = LED_GREEN;
			else
				out_led[i] = LED_RED;
			if (!POWER_ON)
				il_led[i] = 1'b0;
			else if (field_eff[i])
				il_led[i] = flash_q;
			else if (blocked[i])
				il_led[i] = 1'b1;
			else
				il_led[i] = LINKED_ENABLE[i] && !pair_q[i];
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			LED_OUT_A <= LED_DARK;
			LED_OUT_B <= LED_DARK;
			LED_INTERLOCK_A <= 1'b0;
			LED_INTERLOCK_B <= 1'b0;
			warn_q <= 2'h0;
		end
		else
		begin
			LED_OUT_A <= out_led[0];
			LED_INTERLOCK_A <= il_led[0];
			LED_OUT_B <= out_led[1];
			LED_INTERLOCK_B <= il_led[1];
			warn_q <= POWER_ON ? WARN_OCCUPIED : 2'h0;
		end
	end
	assign LED_WARN_A = warn_q[0];
	assign LED_WARN_B = warn_q[1];
endmodule : psl_top

//--- tb/psl_ctl_model.sv
// machine side model: contactor feedback and restart acknowledgment
`timescale 1ns/10ps
module psl_ctl_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic slow,
	input wire logic [1:0] pair,
	input wire logic [1:0] occupied,
	input wire logic [1:0] auto_restart,
	input wire logic [1:0] ack_req,
	input wire logic [1:0] stuck,
	output logic [1:0] fb,
	output logic [1:0] ack
);
	logic [5:0] sh_q;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			sh_q <= 6'h00;
		else
			sh_q <= {sh_q[3:0], pair};
	end

	// closed contact reads high while released; stuck holds it high, as if the contactor never pulls in
	assign fb = ~(slow ? sh_q[5:4] : sh_q[1:0]) | stuck;
	// acknowledge only with a free field in manual mode
	assign ack = ack_req & ~occupied & ~auto_restart;
endmodule : psl_ctl_model

//--- tb/psl_monitor.sv
// assertion checker on the protective output block ports
`timescale 1ns/10ps
module psl_monitor (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic POWER_ON,
	input wire logic TWO_FUNC_MODE,
	input wire logic SAFE_DELAY_EN,
	input wire logic [1:0] FIELD_OCCUPIED,
	input wire logic [1:0] AUTO_RESTART,
	input wire logic [1:0] RESTART_ACK,
	input wire logic [1:0] LINKED_ENABLE,
	input wire logic [6:0] FIELD_PAIR_REQ,
	input wire logic FIELD_PAIR_VALID,
	input wire logic UNIT_SWAP,
	input wire logic CFG_WR,
	input wire logic [3:0] CFG_WADDR,
	input wire logic [1:0] SAFETY_SWITCH_OUTPUT_PAIR,
	input wire logic FIELD_PAIR_FAULT,
	input wire logic [1:0] LED_OUT_A,
	input wire logic LED_INTERLOCK_A,
	input wire logic [1:0] LED_OUT_B
);
	import psl_pkg::*;
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!NRST);
	wire logic [1:0] p = SAFETY_SWITCH_OUTPUT_PAIR;
	////////////////////////////////////////
	sequence s_swap;
		$rose(UNIT_SWAP);
	endsequence
	sequence s_burst;
		(CFG_WR && CFG_WADDR == 4'h0) ##1 CFG_WR [*7] ##1 CFG_WR [*8] ##1 !CFG_WR;
	endsequence
	// changeover may treat the field as occupied, so idle excludes a pending request
	sequence s_idle_free;
		(POWER_ON && !FIELD_OCCUPIED[0] && LINKED_ENABLE[0] && !p[0] && !FIELD_PAIR_VALID) [*4];
	endsequence
	////////////////////////////////////////
	a_occ_pair_off: assert property (FIELD_OCCUPIED[0] |-> ##[1:2] !p[0])
		else $error("pair A stays on with field occupied");
	a_restart_free: assert property ($rose(p[0]) |-> !$past(FIELD_OCCUPIED[0])
		&& !$past(FIELD_OCCUPIED[0], 2))
		else $error("pair A restored without free field");
	a_manual_ack: assert property ($rose(p[0]) && !AUTO_RESTART[0] |-> $past(RESTART_ACK[0])
		|| $past(RESTART_ACK[0], 2) || $past(RESTART_ACK[0], 3))
		else $error("pair A restored without acknowledge");
	a_safe_delay: assert property ($fell(p[0]) && p[1] && !TWO_FUNC_MODE && SAFE_DELAY_EN
		|-> p[1] [*8] ##[11:15] !p[1])
		else $error("pair B delay wrong");
	a_bad_pair: assert property (FIELD_PAIR_VALID && FIELD_PAIR_REQ > 7'h63
		|-> ##[1:3] FIELD_PAIR_FAULT)
		else $error("illegal field pair not flagged");
	a_green_a: assert property ($rose(LED_OUT_A == LED_GREEN) |-> ##[0:2] p[0])
		else $error("green without pair on");
	a_dark_off: assert property ($past(!POWER_ON) |-> LED_OUT_A == LED_DARK
		&& LED_OUT_B == LED_DARK)
		else $error("indicator lit while unit off");
	a_occ_flash: assert property ((POWER_ON && FIELD_OCCUPIED[0]) [*8]
		|-> ##[0:5] $changed(LED_INTERLOCK_A))
		else $error("interlock indicator not flashing");
	a_free_steady: assert property (s_idle_free |-> LED_INTERLOCK_A)
		else $error("interlock indicator not steady");
	a_cfg_burst: assert property (s_swap |-> ##[1:3] s_burst)
		else $error("configuration copy burst wrong");
endmodule : psl_monitor

bind psl_top psl_monitor psl_monitor_i (.*);

//--- tb/tb.sv
// self-checking bench for the protective output and status indicator block
`timescale 1ns/10ps
module tb;
	import psl_pkg::*;
	logic CORE_CLK, NRST, POWER_ON, TWO_FUNC_MODE, SAFE_DELAY_EN, FIELD_PAIR_VALID;
	logic UNIT_SWAP, CFG_WR, CFG_XFER_BUSY, FIELD_PAIR_FAULT, LED_INTERLOCK_A;
	logic LED_INTERLOCK_B, LED_WARN_A, LED_WARN_B, slow;
	logic [1:0] FIELD_OCCUPIED, WARN_OCCUPIED, AUTO_RESTART, RESTART_ACK, CONTACTOR_FB;
	logic [1:0] CONTACTOR_SUPERVISION_EN, EXT_ERROR, EXT_LOCK, LINKED_ENABLE, DIAG_IN;
	logic [1:0] SAFETY_SWITCH_OUTPUT_PAIR, LED_OUT_A, LED_OUT_B, ack_req, stuck;
	logic [6:0] FIELD_PAIR_REQ, ACTIVE_FIELD_PAIR;
	logic [26:0] SIG_SEL;
	logic [7:0] CU_MEM_RDATA, CFG_WDATA;
	logic [3:0] CU_MEM_ADDR, CFG_WADDR;
	logic [8:0] SIG_OUT;
	logic [7:0] mem [16];
	logic [11:0] q [$];
	logic [16:0] rnd;
	int n_errors, n_checks, k;

	assign CU_MEM_RDATA = mem[CU_MEM_ADDR];
	psl_top #(.AUTO_RESET_CYC(50), .SAFE_DLY_CYC(20), .FLASH_CYC(4)) psl_top_i (.*);
	psl_ctl_model psl_ctl_model_i (.clk(CORE_CLK), .nrst(NRST), .slow(slow),
		.pair(SAFETY_SWITCH_OUTPUT_PAIR), .occupied(FIELD_OCCUPIED),
		.auto_restart(AUTO_RESTART), .ack_req(ack_req), .stuck(stuck),
		.fb(CONTACTOR_FB), .ack(RESTART_ACK));
	////////////////////////////////////////
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction : lfsr

	task automatic summarize();
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge CORE_CLK);
	endtask : cyc

	task automatic wait_pair(input int i, input logic v, input int m);
		int j;
		for (j = 0; j < m && SAFETY_SWITCH_OUTPUT_PAIR[i] !== v; j++)
			cyc(1);
		chk(SAFETY_SWITCH_OUTPUT_PAIR[i], v);
		if (j == m)
			summarize();
	endtask : wait_pair
	////////////////////////////////////////
	initial
	begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end

	// copy burst results are matched against the oldest noted word
	always @(negedge CORE_CLK)
	begin
		if (CFG_WR === 1'b1)
		begin
			if (q.size() == 0)
				chk(12'h001, 12'h000);
			else
				chk({CFG_WADDR, CFG_WDATA}, q.pop_front());
		end
	end

	initial
	begin
		{NRST, POWER_ON, SAFE_DELAY_EN, FIELD_PAIR_VALID, UNIT_SWAP, slow} = '0;
		{FIELD_OCCUPIED, WARN_OCCUPIED, AUTO_RESTART, EXT_ERROR, EXT_LOCK} = '0;
		{DIAG_IN, ack_req, stuck, FIELD_PAIR_REQ, SIG_SEL} = '0;
		{TWO_FUNC_MODE, CONTACTOR_SUPERVISION_EN, LINKED_ENABLE} = 5'h1f;
		rnd = 17'h1_8368;
		for (k = 0; k < 16; k++)
		begin
			rnd = lfsr(rnd);
			mem[k] = rnd[7:0];
		end
		cyc(6);
		NRST = 1'b1;
		cyc(3);
		chk(LED_OUT_A, LED_DARK);
		POWER_ON = 1'b1;
		cyc(10);
		chk(SAFETY_SWITCH_OUTPUT_PAIR, 2'h0);
		chk(LED_OUT_A, LED_RED);
		chk({LED_INTERLOCK_B, LED_INTERLOCK_A}, 2'h3);
		slow = 1'b1;
		ack_req = 2'h1;
		cyc(1);
		ack_req = 2'h0;
		wait_pair(0, 1'b1, 8);
		chk(SAFETY_SWITCH_OUTPUT_PAIR[1], 1'b0);
		cyc(3);
		chk({LED_OUT_B, LED_OUT_A}, {LED_RED, LED_GREEN});
		FIELD_OCCUPIED = 2'h1;
		cyc(3);
		chk(SAFETY_SWITCH_OUTPUT_PAIR[0], 1'b0);
		cyc(12);
		AUTO_RESTART = 2'h3;
		FIELD_OCCUPIED = 2'h0;
		wait_pair(0, 1'b1, 8);
		wait_pair(1, 1'b1, 8);
		FIELD_OCCUPIED = 2'h2;
		cyc(3);
		chk(SAFETY_SWITCH_OUTPUT_PAIR, 2'h1);
		FIELD_OCCUPIED = 2'h0;
		wait_pair(1, 1'b1, 8);
		EXT_ERROR = 2'h1;
		cyc(3);
		EXT_ERROR = 2'h0;
		chk(SAFETY_SWITCH_OUTPUT_PAIR[0], 1'b0);
		cyc(40);
		chk(SAFETY_SWITCH_OUTPUT_PAIR[0], 1'b0);
		wait_pair(0, 1'b1, 30);
		TWO_FUNC_MODE = 1'b0;
		SAFE_DELAY_EN = 1'b1;
		cyc(5);
		FIELD_OCCUPIED = 2'h1;
		cyc(12);
		chk(SAFETY_SWITCH_OUTPUT_PAIR, 2'h2);
		cyc(15);
		chk(SAFETY_SWITCH_OUTPUT_PAIR, 2'h0);
		{FIELD_OCCUPIED, TWO_FUNC_MODE, SAFE_DELAY_EN} = 4'h2;
		wait_pair(1, 1'b1, 8);
		for (k = 0; k < 8; k++)
		begin
			rnd = lfsr(rnd);
			SIG_SEL = {9{k[2:0]}};
			{WARN_OCCUPIED, DIAG_IN} = rnd[3:0];
			cyc(3);
			chk({LED_WARN_B, LED_WARN_A}, WARN_OCCUPIED);
			if (k == 1)
				chk(SIG_OUT, {WARN_OCCUPIED[0], {4{WARN_OCCUPIED}}});
			else if (k == 3)
				chk(SIG_OUT, {DIAG_IN[0], {4{DIAG_IN}}});
			else if (k == 0)
				chk(SIG_OUT, 9'h1ff);
			else
				chk(SIG_OUT, 9'h000);
		end
		FIELD_PAIR_REQ = 7'h05;
		FIELD_PAIR_VALID = 1'b1;
		cyc(1900);
		chk(ACTIVE_FIELD_PAIR, 7'h00);
		for (k = 0; k < 300 && ACTIVE_FIELD_PAIR !== 7'h05; k++)
			cyc(1);
		chk(ACTIVE_FIELD_PAIR, 7'h05);
		FIELD_PAIR_REQ = 7'h78;
		cyc(6);
		chk({FIELD_PAIR_FAULT, SAFETY_SWITCH_OUTPUT_PAIR}, 3'h4);
		FIELD_PAIR_REQ = 7'h05;
		cyc(4);
		chk(FIELD_PAIR_FAULT, 1'b0);
		wait_pair(0, 1'b1, 80);
		for (k = 0; k < 16; k++)
			q.push_back({k[3:0], mem[k]});
		UNIT_SWAP = 1'b1;
		cyc(1);
		UNIT_SWAP = 1'b0;
		cyc(20);
		chk({CFG_XFER_BUSY, 11'(q.size())}, 12'h000);
		stuck = 2'h1;
		wait_pair(0, 1'b0, 31000);
		chk(SAFETY_SWITCH_OUTPUT_PAIR[1], 1'b1);
		EXT_LOCK = 2'h2;
		cyc(1);
		EXT_LOCK = 2'h0;
		cyc(20);
		chk(SAFETY_SWITCH_OUTPUT_PAIR, 2'h0);
		cyc(50);
		chk(SAFETY_SWITCH_OUTPUT_PAIR, 2'h1);
		summarize();
	end
endmodule : tb
